/* File: logic/aeu_pkg.sv */
/*
  aeu_pkg: shared constants and types for the addressing-mode operand
  address unit. Assumes an 8-bit data path and a 16-bit address space.
*/
`default_nettype none
package aeu_pkg;
  localparam int AEU_DW = 8;
  localparam int AEU_AW = 16;
  // program counter advances per instruction length
  localparam logic [15:0] AEU_LEN1 = 16'h0001;
  localparam logic [15:0] AEU_LEN2 = 16'h0002;
  localparam logic [15:0] AEU_LEN3 = 16'h0003;
  localparam logic [7:0] AEU_ZERO_PAGE = 8'h00;
  // flag register bit positions
  localparam int AEU_FLG_BORROW = 0;
  localparam int AEU_FLG_NIBBLE = 4;
  localparam int AEU_NIBBLE_BIT = 3;
  localparam logic [4:0] AEU_FLAGS_RST = 5'h00;
  // one-hot mode select
  typedef enum logic [9:0] {
    AEU_OPCODE_ONLY_MODE     = 10'b00_0000_0001,
    AEU_LITERAL_OPERAND_MODE = 10'b00_0000_0010,
    AEU_ZERO_PAGE_MODE       = 10'b00_0000_0100,
    AEU_LONG_ABSOLUTE_MODE   = 10'b00_0000_1000,
    AEU_INDEX_NO_OFFSET_MODE = 10'b00_0001_0000,
    AEU_INDEX_BYTE_OFFSET_MODE = 10'b00_0010_0000,
    AEU_INDEX_WORD_OFFSET_MODE = 10'b00_0100_0000,
    AEU_BRANCH_OFFSET_MODE   = 10'b00_1000_0000,
    AEU_BIT_MODIFY_MODE      = 10'b01_0000_0000,
    AEU_BIT_TEST_BRANCH_MODE = 10'b10_0000_0000
  } aeu_mode_t;
endpackage
`default_nettype wire

/* File: logic/aeu_adder.sv */
/*
  aeu_adder: 16-bit address adder of a base and a byte, sign-extended when signed_i is set, else zero-extended.
  Assumes the caller keeps the sum modulo 2^16.
*/
`timescale 1ns/1ps
`default_nettype none
module aeu_adder (
  // operands
  input wire logic [15:0] base_i,
  input wire logic [7:0] offs_i,
  input wire logic signed_i,
  // result
  output logic [15:0] sum_o
);
  logic [15:0] long_absolute_mode;
  // extend the offset by sign or by zero
  assign long_absolute_mode = {{8{signed_i & offs_i[7]}}, offs_i};
  assign sum_o = base_i + long_absolute_mode; // wraps modulo the address space
endmodule // aeu_adder
`default_nettype wire

/* File: logic/aeu_unit.sv */
/*
  aeu_unit: operand address, address bus bytes and next program counter
  for ten addressing modes, plus bit-test flag and nibble-carry update.
  Assumes decode supplies the mode, opcode and the two following bytes
  in the same cycle as start_i, and that start_i is a one-cycle strobe.
*/
// Contract
// - opcode only mode, one byte, no operand
// - literal operand at PC+1, PC advances two
// - zero page uses upper zero, lower byte1
// - long absolute byte1 high, byte2 low, PC+3
// - index no offset, pointer low, PC+1
// - pointer plus byte1, carry to upper byte
// - pointer plus byte2, carry into byte1, PC+3
// - branch to PC+2+offset when condition holds
// - bit modify on zero page byte1, PC+2
// - bit test branches PC+3+byte2 on match
// - tested bit copied into borrow flag
// - nibble carry from bit three of results
`timescale 1ns/1ps
`default_nettype none
module aeu_unit
  import aeu_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // decode side
  input wire logic start_i,
  input wire aeu_mode_t mode_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] byte1_i,
  input wire logic [7:0] byte2_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] index_i,
  input wire logic cond_i,
  // zero-page data read for the bit test
  input wire logic [7:0] test_data_i,
  // arithmetic result nibble carry
  input wire logic alu_upd_i,
  input wire logic [3:0] alu_a_i,
  input wire logic [3:0] alu_b_i,
  input wire logic alu_cin_i,
  // results
  output logic valid_o,
  output logic [15:0] ea_o,
  output logic [7:0] addr_hi_o,
  output logic [7:0] addr_lo_o,
  output logic [15:0] pc_nxt_o,
  output logic has_operand_o,
  output logic [2:0] bit_sel_o,
  output logic taken_o,
  output logic [4:0] flags_o
);
  logic [15:0] ea_nxt, pcn_nxt, rel_base, rel_sum;
  logic [15:0] pc2, pc3;
  logic [8:0] lo_sum;
  logic [7:0] hi_nxt, lo_nxt;
  logic oper_nxt, take_nxt, tested_bit, match;
  logic [15:0] ea_r, pcn_r;
  logic [7:0] hi_r, lo_r;
  logic [2:0] bit_r;
  logic valid_r, oper_r, take_r;
  logic [4:0] flags_r;
  logic [4:0] nib_sum;

  // add a length to the program counter, wrapping
  function automatic logic [15:0] pc_add(input logic [15:0] pc,
                                         input logic [15:0] len);
    pc_add = pc + len;
  endfunction

  // fixed-length program counter advances
  assign pc2 = pc_add(pc_i, AEU_LEN2);
  assign pc3 = pc_add(pc_i, AEU_LEN3);
  // relative branch base depends on instruction length
  assign rel_base = (mode_i == AEU_BIT_TEST_BRANCH_MODE) ? pc3 : pc2;

  // signed offset: byte1 for branches, byte2 for bit test
  aeu_adder u_rel (
    .base_i(rel_base),
    .offs_i((mode_i == AEU_BIT_TEST_BRANCH_MODE) ? byte2_i : byte1_i),
    .signed_i(1'b1),
    .sum_o(rel_sum)
  );

  // index sums keep the carry for the upper byte
  assign lo_sum = (mode_i == AEU_INDEX_WORD_OFFSET_MODE) ?
                  ({1'b0, index_i} + {1'b0, byte2_i}) :
                  ({1'b0, index_i} + {1'b0, byte1_i});
  // bit number lives in opcode bits 3:1, sense in bit 0 (0 = set)
  assign tested_bit = test_data_i[opcode_i[3:1]];
  assign match = tested_bit ^ opcode_i[0];

  // mode decode
  always_comb begin
    ea_nxt = pc_i;
    hi_nxt = AEU_ZERO_PAGE;
    lo_nxt = 8'h00;
    pcn_nxt = pc_add(pc_i, AEU_LEN1);
    oper_nxt = 1'b0;
    take_nxt = 1'b0;
    unique case (mode_i)
      AEU_OPCODE_ONLY_MODE: begin
        pcn_nxt = pc_add(pc_i, AEU_LEN1);
      end
      AEU_LITERAL_OPERAND_MODE: begin
        ea_nxt = pc_add(pc_i, AEU_LEN1);
        pcn_nxt = pc2;
        oper_nxt = 1'b1;
      end
      AEU_ZERO_PAGE_MODE, AEU_BIT_MODIFY_MODE: begin
        hi_nxt = AEU_ZERO_PAGE;
        lo_nxt = byte1_i;
        pcn_nxt = pc2;
        oper_nxt = 1'b1;
      end
      AEU_LONG_ABSOLUTE_MODE: begin
        hi_nxt = byte1_i;
        lo_nxt = byte2_i;
        pcn_nxt = pc3;
        oper_nxt = 1'b1;
      end
      AEU_INDEX_NO_OFFSET_MODE: begin
        lo_nxt = index_i;
        pcn_nxt = pc_add(pc_i, AEU_LEN1);
        oper_nxt = 1'b1;
      end
      AEU_INDEX_BYTE_OFFSET_MODE: begin
        hi_nxt = {7'h00, lo_sum[8]};
        lo_nxt = lo_sum[7:0];
        pcn_nxt = pc2;
        oper_nxt = 1'b1;
      end
      AEU_INDEX_WORD_OFFSET_MODE: begin
        hi_nxt = byte1_i + {7'h00, lo_sum[8]};
        lo_nxt = lo_sum[7:0];
        pcn_nxt = pc3;
        oper_nxt = 1'b1;
      end
      AEU_BRANCH_OFFSET_MODE: begin
        ea_nxt = cond_i ? rel_sum : pc2;
        pcn_nxt = cond_i ? rel_sum : pc2;
        take_nxt = cond_i;
      end
      AEU_BIT_TEST_BRANCH_MODE: begin
        lo_nxt = byte1_i;
        pcn_nxt = match ? rel_sum : pc3;
        take_nxt = match;
        oper_nxt = 1'b1;
      end
      default: begin
        pcn_nxt = pc_add(pc_i, AEU_LEN1);
      end
    endcase
    if (mode_i != AEU_LITERAL_OPERAND_MODE &&
        mode_i != AEU_OPCODE_ONLY_MODE &&
        mode_i != AEU_BRANCH_OFFSET_MODE) begin
      ea_nxt = {hi_nxt, lo_nxt};
    end
  end

  // result registers, loaded on each start
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ea_r <= 16'h0000;
      pcn_r <= 16'h0000;
      hi_r <= 8'h00;
      lo_r <= 8'h00;
      bit_r <= 3'h0;
      oper_r <= 1'b0;
      take_r <= 1'b0;
    end else if (start_i) begin
      ea_r <= ea_nxt;
      pcn_r <= pcn_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      bit_r <= opcode_i[3:1];
      oper_r <= oper_nxt;
      take_r <= take_nxt;
    end
  end

  // result valid strobe, one cycle after start
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= start_i;
    end
  end

  // low-nibble sum; bit 4 is the carry out of bit three
  assign nib_sum = {1'b0, alu_a_i} + {1'b0, alu_b_i} + {4'h0, alu_cin_i};

  // flag register: borrow from bit test, nibble carry from arithmetic
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_r <= AEU_FLAGS_RST;
    end else begin
      if (start_i && mode_i == AEU_BIT_TEST_BRANCH_MODE) begin
        flags_r[AEU_FLG_BORROW] <= tested_bit;
      end
      if (alu_upd_i) begin
        flags_r[AEU_FLG_NIBBLE] <= nib_sum[AEU_NIBBLE_BIT + 1];
      end
    end
  end

  // outputs straight from the result flip-flops
  assign valid_o = valid_r;
  assign ea_o = ea_r;
  assign addr_hi_o = hi_r;
  assign addr_lo_o = lo_r;
  assign pc_nxt_o = pcn_r;
  assign has_operand_o = oper_r;
  assign bit_sel_o = bit_r;
  assign taken_o = take_r;
  assign flags_o = flags_r;
endmodule // aeu_unit
`default_nettype wire

/* File: test/aeu_mem_model.sv */
/* aeu_mem_model: zero-page memory behind the bit test.
   assumes a combinational read addressed by the first byte. */
`timescale 1ns/1ps
`default_nettype none
module aeu_mem_model (
  // read port
  input wire logic [7:0] addr_i,
  output logic [7:0] data_o
);
  // fixed contents that differ per location
  assign data_o = addr_i ^ 8'h5a;
endmodule // aeu_mem_model
`default_nettype wire

/* File: test/aeu_unit_assertions.sv */
/* aeu_unit_assertions: timing, address and flag checks on aeu_unit.
   assumes a bind with matching port names. */
`timescale 1ns/1ps
`default_nettype none
module aeu_unit_assertions
  import aeu_pkg::*;
(
  // clock, reset and decode side
  input wire logic mclk_i, reset_n_i, start_i, cond_i,
  input wire aeu_mode_t mode_i,
  input wire logic [7:0] opcode_i, byte1_i, byte2_i, index_i, test_data_i,
  input wire logic [15:0] pc_i,
  // results
  input wire logic valid_o, has_operand_o, taken_o,
  input wire logic [15:0] ea_o, pc_nxt_o,
  input wire logic [7:0] addr_hi_o, addr_lo_o,
  input wire logic [2:0] bit_sel_o,
  input wire logic [4:0] flags_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // one result per start, one cycle later
  AST_VALID: assert property (valid_o == $past(start_i))
    else $error("valid does not follow start");
  // addresses and next pc per mode, then borrow flag and bit select
  AST_ONLY: assert property (start_i && mode_i == AEU_OPCODE_ONLY_MODE |=>
    pc_nxt_o == $past(pc_i) + 16'h0001 && !has_operand_o) else $error("only");
  AST_LIT: assert property (start_i && mode_i == AEU_LITERAL_OPERAND_MODE |=>
    ea_o == $past(pc_i) + 16'h0001 && pc_nxt_o == $past(pc_i) + 16'h0002)
    else $error("literal");
  AST_ZP: assert property (start_i && mode_i == AEU_ZERO_PAGE_MODE |=>
    {addr_hi_o, addr_lo_o} == {8'h00, $past(byte1_i)}) else $error("zp");
  AST_LONG: assert property (start_i && mode_i == AEU_LONG_ABSOLUTE_MODE |=>
    ea_o == {$past(byte1_i), $past(byte2_i)}) else $error("long");
  AST_IX: assert property (start_i && mode_i == AEU_INDEX_NO_OFFSET_MODE |=>
    ea_o == {8'h00, $past(index_i)}) else $error("index");
  AST_IX1: assert property (start_i && mode_i == AEU_INDEX_BYTE_OFFSET_MODE |=>
    {addr_hi_o, addr_lo_o} == $past(index_i) + $past(byte1_i))
    else $error("byte offset");
  AST_BRN: assert property (start_i && mode_i == AEU_BRANCH_OFFSET_MODE && !cond_i
    |=> pc_nxt_o == $past(pc_i) + 16'h0002 && !taken_o) else $error("branch");
  AST_BOR: assert property (start_i && mode_i == AEU_BIT_TEST_BRANCH_MODE |=>
    flags_o[0] == $past(test_data_i[opcode_i[3:1]])) else $error("borrow");
  AST_BSEL: assert property (start_i |=> bit_sel_o == $past(opcode_i[3:1]))
    else $error("bit select");
  // main scenarios
  cover property (start_i && mode_i == AEU_BIT_TEST_BRANCH_MODE);
  cover property (valid_o && taken_o);
  cover property (start_i ##1 start_i);
endmodule // aeu_unit_assertions
`default_nettype wire

/* File: test/testbench.sv */
/* testbench: directed and random starts into aeu_unit.
   assumes the memory model feeds the bit-test byte. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aeu_pkg::*;
  logic mclk_i = 0, reset_n_i = 0, start_i = 0, cond_i = 0, alu_upd_i = 0;
  logic alu_cin_i = 0, valid_o, has_operand_o, taken_o, nib = 0, bor = 0;
  aeu_mode_t mode_i = AEU_OPCODE_ONLY_MODE;
  logic [7:0] opcode_i = 0, byte1_i = 0, byte2_i = 0, index_i = 0;
  logic [7:0] test_data_i, addr_hi_o, addr_lo_o;
  logic [15:0] pc_i = 0, ea_o, pc_nxt_o;
  logic [3:0] alu_a_i = 0, alu_b_i = 0;
  logic [2:0] bit_sel_o;
  logic [4:0] flags_o;
  logic [57:0] eq[$], mq[$], mk;
  logic [31:0] seed = 32'h0000_ec4d;
  int mismatches = 0, total_checks = 0;
  aeu_unit aeu_unit_i (.*);
  aeu_mem_model aeu_mem_model_i (.addr_i(byte1_i), .data_o(test_data_i));
  // 125 MHz clock
  always #4 mclk_i = ~mclk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [57:0] seen, input logic [57:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // drive a start most cycles and note the expected result
  initial begin
    logic [15:0] e, n, p;
    logic [7:0] o;
    logic b, t, br, bit_test_branch_mode;
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i) reset_n_i = 1;
    check(58'({valid_o, flags_o}), 58'h0);
    for (int i = 0; i < 400; i++) begin
      @(negedge mclk_i);
      start_i = i < 10 || rnd() % 4 != 0;
      mode_i = aeu_mode_t'(10'h001 << (i < 10 ? i : rnd() % 10));
      pc_i = i < 10 ? 16'hfffe : 16'(rnd());
      {opcode_i, byte1_i, byte2_i, index_i} = rnd();
      {cond_i, alu_upd_i, alu_cin_i, alu_a_i, alu_b_i} = 11'(rnd());
      #1;
      p = pc_i;
      br = mode_i == AEU_BRANCH_OFFSET_MODE;
      bit_test_branch_mode = mode_i == AEU_BIT_TEST_BRANCH_MODE;
      b = test_data_i[opcode_i[3:1]];
      t = br ? cond_i : (bit_test_branch_mode && (b ^ opcode_i[0]));
      o = br ? byte1_i : byte2_i;
      if (alu_upd_i) nib = ({1'b0, alu_a_i} + alu_b_i + alu_cin_i) > 5'h0f;
      if (start_i && bit_test_branch_mode) bor = b;
      case (mode_i)
        AEU_OPCODE_ONLY_MODE, AEU_INDEX_NO_OFFSET_MODE: n = p + 16'h0001;
        AEU_LONG_ABSOLUTE_MODE, AEU_INDEX_WORD_OFFSET_MODE,
          AEU_BIT_TEST_BRANCH_MODE: n = p + 16'h0003;
        default: n = p + 16'h0002;
      endcase
      if (t) n = n + {{8{o[7]}}, o};
      case (mode_i)
        AEU_OPCODE_ONLY_MODE: e = p;
        AEU_LITERAL_OPERAND_MODE: e = p + 16'h0001;
        AEU_LONG_ABSOLUTE_MODE: e = {byte1_i, byte2_i};
        AEU_INDEX_NO_OFFSET_MODE: e = {8'h00, index_i};
        AEU_INDEX_BYTE_OFFSET_MODE: e = index_i + byte1_i;
        AEU_INDEX_WORD_OFFSET_MODE: e = {byte1_i, byte2_i} + index_i;
        AEU_BRANCH_OFFSET_MODE: e = n;
        default: e = {8'h00, byte1_i};
      endcase
      mk = {16'hffff,
        (br || mode_i == AEU_LITERAL_OPERAND_MODE) ? 16'h0000 : 16'hffff,
        16'hffff, 1'b1, 5'h1f, 4'hf};
      if (start_i) begin
        mq.push_back(mk);
        eq.push_back({e, mode_i == AEU_OPCODE_ONLY_MODE ? 16'h0000 : e, n, t,
          nib, 3'b000, bor, !(br || mode_i == AEU_OPCODE_ONLY_MODE),
          opcode_i[3:1]} & mk);
      end
    end
    @(negedge mclk_i) start_i = 0;
    repeat (2) @(negedge mclk_i);
    check(58'(eq.size()), 58'h0);
    results();
  end
  // compare each result with the oldest note
  always @(negedge mclk_i) if (valid_o === 1'b1) begin
    check({ea_o, addr_hi_o, addr_lo_o, pc_nxt_o, taken_o, flags_o,
      has_operand_o, bit_sel_o} & mq.pop_front(),
      eq.pop_front());
  end
  // cut a hang short
  initial begin
    #10000;
    mismatches++;
    results();
  end
endmodule // testbench
bind aeu_unit aeu_unit_assertions aeu_unit_assertions_i (.*);
`default_nettype wire
